// File: src/rcs_pkg.sv
package rcs_pkg;

    // Start-up delay length, in system clock pulses
    localparam int unsigned       STARTUP_CYCLES = 1024;
    localparam int unsigned       STARTUP_CNT_W  = 11;
    localparam logic [10:0]       STARTUP_ZERO   = 11'h000;
    localparam logic [10:0]       STARTUP_ONE    = 11'h001;
    localparam logic [10:0]       STARTUP_LAST   = 11'(STARTUP_CYCLES - 1);

    // Watchdog: eight divider stages
    localparam int unsigned       WDT_W          = 8;
    localparam logic [WDT_W-1:0]  WDT_CLEAR      = 8'h00;
    localparam logic [WDT_W-1:0]  WDT_ONE        = 8'h01;
    localparam logic [WDT_W-1:0]  WDT_LAST       = 8'hff;

    // Core reset values
    localparam int unsigned       PC_W           = 16;
    localparam logic [PC_W-1:0]   PC_RESET       = 16'h0000;
    localparam int unsigned       SP_W           = 3;
    localparam logic [SP_W-1:0]   SP_TOP         = 3'h0;

    // Register port
    localparam int unsigned       ADDR_W         = 4;
    localparam int unsigned       DATA_W         = 8;
    localparam logic [ADDR_W-1:0] ADDR_CAUSE     = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT  = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_CTRL      = 4'h3;
    localparam logic [DATA_W-1:0] DATA_ZERO      = 8'h00;

    // Cause register fields
    localparam int unsigned       CAUSE_TO_BIT   = 0;
    localparam int unsigned       CAUSE_PD_BIT   = 1;
    localparam int unsigned       CAUSE_HALT_BIT = 2;
    localparam int unsigned       CAUSE_HOLD_BIT = 3;

    // Interrupt status / mask fields
    localparam int unsigned       IRQ_W          = 3;
    localparam int unsigned       EV_CHIP_BIT    = 0;
    localparam int unsigned       EV_WARM_BIT    = 1;
    localparam int unsigned       EV_WAKE_BIT    = 2;
    localparam logic [IRQ_W-1:0]  IRQ_CLEAR      = 3'h0;

    // Control register fields
    localparam int unsigned       CTRL_WDT_EN_BIT = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET      = 8'h01;

    typedef enum logic [2:0] {
        ST_POR,
        ST_PIN,
        ST_DELAY,
        ST_RUN,
        ST_HALT
    } rcs_state_t;

endpackage : rcs_pkg

// File: src/rcs_timer_if.sv
`timescale 1ns/1ps
interface rcs_timer_if;
    logic start;
    logic busy;
    logic done;

    modport timer (input start, output busy, output done);
    modport ctrl  (output start, input busy, input done);
endinterface : rcs_timer_if

// File: src/rcs_startup_timer.sv
`timescale 1ns/1ps
module rcs_startup_timer (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    rcs_timer_if.timer        tif
);
    logic [rcs_pkg::STARTUP_CNT_W-1:0] cnt_q;
    logic [rcs_pkg::STARTUP_CNT_W-1:0] cnt_d;
    logic                              busy_q;
    logic                              busy_d;
    logic                              done_q;
    logic                              done_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (tif.start)
        begin
            // Restart wins so a new wake always gets the full delay
            cnt_d  = rcs_pkg::STARTUP_ZERO;
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            if (cnt_q == rcs_pkg::STARTUP_LAST)
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
            else
            begin
                cnt_d = cnt_q + rcs_pkg::STARTUP_ONE;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_q  <= rcs_pkg::STARTUP_ZERO;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign tif.busy = busy_q;
    assign tif.done = done_q;

endmodule : rcs_startup_timer

// File: src/rcs_reset_cause_sequencer.sv
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Chip resets come only from power-on, the pin in run, halt or wake delay, and a watchdog timeout in run.
// - A watchdog timeout in halt is a warm reset that clears only program counter and stack pointer.
// - Cause flags: power-up 00, pin in run unchanged, pin in halt 0/1, timeout run 1/u, timeout halt 1/1.
// - The start-up delay lasts 1024 system clock pulses.
// - The delay is applied at power-up and skipped for a pin reset in normal operation.
// - Every wake from halt passes through the start-up delay before running again.
// - A chip reset clears the watchdog, which counts again as soon as the reset ends.
// - A chip reset loads program counter 000H and the stack pointer with the top of stack.
// - A chip reset disables interrupts by clearing the interrupt mask.
// - Data registers are never reset by this block, so they survive every reset except power-on.
// - Control registers take initial values on a chip reset and are kept on a warm reset.
// - The powerdown flag clears at power-up or watchdog clear and sets on halt entry.
module rcs_reset_cause_sequencer (
    input  wire logic                         core_clk,
    input  wire logic                         rst_n,
    input  wire logic                         clk_en,
    input  wire logic                         external_reset_pin_n,
    input  wire logic                         halt_exec,
    input  wire logic                         wdt_clear_exec,
    input  wire logic                         wdt_tick,
    input  wire logic                         wake_req,
    input  wire logic [rcs_pkg::ADDR_W-1:0]   reg_addr,
    input  wire logic [rcs_pkg::DATA_W-1:0]   reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output logic      [rcs_pkg::DATA_W-1:0]   reg_rdata,
    output logic                              irq,
    output logic                              chip_reset,
    output logic                              warm_reset,
    output logic                              core_stall,
    output logic      [rcs_pkg::PC_W-1:0]     pc_init,
    output logic      [rcs_pkg::SP_W-1:0]     sp_init,
    output logic                              pc_sp_load,
    output logic                              timeout_flag,
    output logic                              powerdown_flag
);
    rcs_timer_if tif ();

    rcs_startup_timer u_startup_delay_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clk_en   (clk_en),
        .tif      (tif)
    );

    function automatic logic hit(input logic [rcs_pkg::ADDR_W-1:0] a,
                                 input logic [rcs_pkg::ADDR_W-1:0] r);
        hit = (a == r);
    endfunction : hit

    rcs_pkg::rcs_state_t                state_q;
    rcs_pkg::rcs_state_t                state_d;
    logic                               wake_pend_q;
    logic                               wake_pend_d;
    logic                               delay_rst_q;
    logic                               delay_rst_d;
    logic                               start_q;
    logic                               start_d;
    logic                               to_q;
    logic                               to_d;
    logic                               pd_q;
    logic                               pd_d;
    logic [rcs_pkg::WDT_W-1:0]          wdt_q;
    logic [rcs_pkg::WDT_W-1:0]          wdt_d;
    logic                               chip_rst_q;
    logic                               chip_rst_d;
    logic                               warm_q;
    logic                               warm_d;
    logic                               stall_q;
    logic                               stall_d;
    logic [rcs_pkg::PC_W-1:0]           pc_q;
    logic [rcs_pkg::PC_W-1:0]           pc_d;
    logic [rcs_pkg::SP_W-1:0]           sp_q;
    logic [rcs_pkg::SP_W-1:0]           sp_d;
    logic                               load_q;
    logic                               load_d;
    logic [rcs_pkg::IRQ_W-1:0]          stat_q;
    logic [rcs_pkg::IRQ_W-1:0]          stat_d;
    logic [rcs_pkg::IRQ_W-1:0]          mask_q;
    logic [rcs_pkg::IRQ_W-1:0]          mask_d;
    logic [rcs_pkg::DATA_W-1:0]         ctrl_q;
    logic [rcs_pkg::DATA_W-1:0]         ctrl_d;
    logic [rcs_pkg::DATA_W-1:0]         rdata_q;
    logic [rcs_pkg::DATA_W-1:0]         rdata_d;
    logic                               irq_q;
    logic                               irq_d;
    logic                               wdt_timeout;
    logic                               wdt_clr;
    logic [rcs_pkg::IRQ_W-1:0]          ev;

    assign tif.start = start_q;

    // Watchdog overflow; not counted while the chip is held in reset
    assign wdt_timeout = ctrl_q[rcs_pkg::CTRL_WDT_EN_BIT] && wdt_tick && !chip_rst_q
                         && (wdt_q == rcs_pkg::WDT_LAST);

    always_comb
    begin
        state_d     = state_q;
        wake_pend_d = wake_pend_q;
        delay_rst_d = delay_rst_q;
        start_d     = 1'b0;
        to_d        = to_q;
        pd_d        = pd_q;
        warm_d      = 1'b0;
        wdt_clr     = 1'b0;
        ev          = rcs_pkg::IRQ_CLEAR;
        unique case (state_q)
            rcs_pkg::ST_POR:
            begin
                // Reset start_q is set, so the delay runs from the first enabled edge
                if (tif.done)
                begin
                    state_d = external_reset_pin_n ? rcs_pkg::ST_RUN : rcs_pkg::ST_PIN;
                end
            end
            rcs_pkg::ST_RUN:
            begin
                if (!external_reset_pin_n)
                begin
                    // Flags left unchanged; no delay for a pin reset in run
                    state_d     = rcs_pkg::ST_PIN;
                    wake_pend_d = 1'b0;
                    ev[rcs_pkg::EV_CHIP_BIT] = 1'b1;
                end
                else if (wdt_timeout)
                begin
                    to_d        = 1'b1;
                    state_d     = rcs_pkg::ST_PIN;
                    wake_pend_d = 1'b0;
                    ev[rcs_pkg::EV_CHIP_BIT] = 1'b1;
                end
                else if (halt_exec)
                begin
                    pd_d    = 1'b1;
                    to_d    = 1'b0;
                    wdt_clr = 1'b1;
                    state_d = rcs_pkg::ST_HALT;
                end
                else if (wdt_clear_exec)
                begin
                    pd_d    = 1'b0;
                    wdt_clr = 1'b1;
                end
            end
            rcs_pkg::ST_HALT:
            begin
                if (!external_reset_pin_n)
                begin
                    to_d        = 1'b0;
                    pd_d        = 1'b1;
                    state_d     = rcs_pkg::ST_PIN;
                    wake_pend_d = 1'b1;
                    ev[rcs_pkg::EV_CHIP_BIT] = 1'b1;
                end
                else if (wdt_timeout)
                begin
                    to_d        = 1'b1;
                    pd_d        = 1'b1;
                    warm_d      = 1'b1;
                    start_d     = 1'b1;
                    delay_rst_d = 1'b0;
                    state_d     = rcs_pkg::ST_DELAY;
                    ev[rcs_pkg::EV_WARM_BIT] = 1'b1;
                end
                else if (wake_req)
                begin
                    start_d     = 1'b1;
                    delay_rst_d = 1'b0;
                    state_d     = rcs_pkg::ST_DELAY;
                end
            end
            rcs_pkg::ST_PIN:
            begin
                if (external_reset_pin_n)
                begin
                    if (wake_pend_q)
                    begin
                        start_d     = 1'b1;
                        delay_rst_d = 1'b1;
                        state_d     = rcs_pkg::ST_DELAY;
                    end
                    else
                    begin
                        state_d = rcs_pkg::ST_RUN;
                    end
                    wake_pend_d = 1'b0;
                end
            end
            rcs_pkg::ST_DELAY:
            begin
                if (!external_reset_pin_n)
                begin
                    // Pin during a wake: delay restarts after release
                    state_d     = rcs_pkg::ST_PIN;
                    wake_pend_d = 1'b1;
                    ev[rcs_pkg::EV_CHIP_BIT] = 1'b1;
                end
                else if (tif.done)
                begin
                    state_d = rcs_pkg::ST_RUN;
                    ev[rcs_pkg::EV_WAKE_BIT] = 1'b1;
                end
            end
            default:
            begin
                state_d = rcs_pkg::ST_POR;
            end
        endcase

        chip_rst_d = (state_d == rcs_pkg::ST_POR) || (state_d == rcs_pkg::ST_PIN)
                     || ((state_d == rcs_pkg::ST_DELAY) && delay_rst_d);
        stall_d    = (state_d != rcs_pkg::ST_RUN);
        load_d     = chip_rst_d || warm_d;
        pc_d       = load_d ? rcs_pkg::PC_RESET : pc_q;
        sp_d       = load_d ? rcs_pkg::SP_TOP : sp_q;

        // Watchdog held clear in reset, counting resumes on release
        if (chip_rst_q || wdt_clr)
        begin
            wdt_d = rcs_pkg::WDT_CLEAR;
        end
        else if (ctrl_q[rcs_pkg::CTRL_WDT_EN_BIT] && wdt_tick)
        begin
            wdt_d = wdt_q + rcs_pkg::WDT_ONE;
        end
        else
        begin
            wdt_d = wdt_q;
        end
    end

    always_comb
    begin
        ctrl_d  = ctrl_q;
        mask_d  = mask_q;
        stat_d  = stat_q;
        rdata_d = rcs_pkg::DATA_ZERO;
        if (reg_wr && hit(reg_addr, rcs_pkg::ADDR_IRQ_MASK))
        begin
            mask_d = reg_wdata[rcs_pkg::IRQ_W-1:0];
        end
        if (reg_wr && hit(reg_addr, rcs_pkg::ADDR_CTRL))
        begin
            ctrl_d = reg_wdata;
        end
        if (reg_rd && hit(reg_addr, rcs_pkg::ADDR_CAUSE))
        begin
            rdata_d[rcs_pkg::CAUSE_TO_BIT]   = to_q;
            rdata_d[rcs_pkg::CAUSE_PD_BIT]   = pd_q;
            rdata_d[rcs_pkg::CAUSE_HALT_BIT] = (state_q == rcs_pkg::ST_HALT);
            rdata_d[rcs_pkg::CAUSE_HOLD_BIT] = stall_q;
        end
        if (reg_rd && hit(reg_addr, rcs_pkg::ADDR_IRQ_STAT))
        begin
            rdata_d[rcs_pkg::IRQ_W-1:0] = stat_q;
            stat_d                      = rcs_pkg::IRQ_CLEAR;
        end
        if (reg_rd && hit(reg_addr, rcs_pkg::ADDR_IRQ_MASK))
        begin
            rdata_d[rcs_pkg::IRQ_W-1:0] = mask_q;
        end
        if (reg_rd && hit(reg_addr, rcs_pkg::ADDR_CTRL))
        begin
            rdata_d = ctrl_q;
        end
        // New events beat a clearing read in the same cycle
        stat_d = stat_d | ev;
        // Control state reinitialised by a chip reset, kept on a warm reset
        if (chip_rst_q)
        begin
            mask_d = rcs_pkg::IRQ_CLEAR;
            ctrl_d = rcs_pkg::CTRL_RESET;
        end
        irq_d = |(stat_d & mask_d);
    end

    // Only power-on clears the flags here; pin and watchdog resets change them through the next-state logic
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q     <= rcs_pkg::ST_POR;
            wake_pend_q <= 1'b0;
            delay_rst_q <= 1'b0;
            start_q     <= 1'b1;
            to_q        <= 1'b0;
            pd_q        <= 1'b0;
            wdt_q       <= rcs_pkg::WDT_CLEAR;
            chip_rst_q  <= 1'b1;
            warm_q      <= 1'b0;
            stall_q     <= 1'b1;
            pc_q        <= rcs_pkg::PC_RESET;
            sp_q        <= rcs_pkg::SP_TOP;
            load_q      <= 1'b1;
            stat_q      <= rcs_pkg::IRQ_CLEAR;
            mask_q      <= rcs_pkg::IRQ_CLEAR;
            ctrl_q      <= rcs_pkg::CTRL_RESET;
            rdata_q     <= rcs_pkg::DATA_ZERO;
            irq_q       <= 1'b0;
        end
        else if (clk_en)
        begin
            state_q     <= state_d;
            wake_pend_q <= wake_pend_d;
            delay_rst_q <= delay_rst_d;
            start_q     <= start_d;
            to_q        <= to_d;
            pd_q        <= pd_d;
            wdt_q       <= wdt_d;
            chip_rst_q  <= chip_rst_d;
            warm_q      <= warm_d;
            stall_q     <= stall_d;
            pc_q        <= pc_d;
            sp_q        <= sp_d;
            load_q      <= load_d;
            stat_q      <= stat_d;
            mask_q      <= mask_d;
            ctrl_q      <= ctrl_d;
            rdata_q     <= rdata_d;
            irq_q       <= irq_d;
        end
    end

    assign reg_rdata      = rdata_q;
    assign irq            = irq_q;
    assign chip_reset     = chip_rst_q;
    assign warm_reset     = warm_q;
    assign core_stall     = stall_q;
    assign pc_init        = pc_q;
    assign sp_init        = sp_q;
    assign pc_sp_load     = load_q;
    assign timeout_flag   = to_q;
    assign powerdown_flag = pd_q;

endmodule : rcs_reset_cause_sequencer

// File: tb/rcs_assertions.sv
`timescale 1ns/1ps
module rcs_checker (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     clk_en,
    input  wire logic                     external_reset_pin_n,
    input  wire logic                     halt_exec,
    input  wire logic                     chip_reset,
    input  wire logic                     warm_reset,
    input  wire logic                     core_stall,
    input  wire logic [rcs_pkg::PC_W-1:0] pc_init,
    input  wire logic [rcs_pkg::SP_W-1:0] sp_init,
    input  wire logic                     pc_sp_load,
    input  wire logic                     timeout_flag,
    input  wire logic                     powerdown_flag
);
    logic [11:0] por_cnt_q;
    logic [11:0] por_cnt_d;
    logic [11:0] stall_cnt_q;
    logic [11:0] stall_cnt_d;
    logic        halt_seen_q;
    logic        halt_seen_d;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    // Saturating, so long runs never wrap back into the start-up window
    always_comb
    begin
        por_cnt_d   = (por_cnt_q == 12'hfff) ? por_cnt_q : por_cnt_q + 12'h001;
        stall_cnt_d = (stall_cnt_q == 12'hfff) ? stall_cnt_q : stall_cnt_q + 12'h001;
        if (!core_stall)
        begin
            stall_cnt_d = 12'h000;
        end
        halt_seen_d = core_stall ? halt_seen_q : (halt_exec && external_reset_pin_n);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            por_cnt_q   <= 12'h000;
            stall_cnt_q <= 12'h000;
            halt_seen_q <= 1'b0;
        end
        else
        begin
            por_cnt_q   <= por_cnt_d;
            stall_cnt_q <= stall_cnt_d;
            halt_seen_q <= halt_seen_d;
        end
    end

    a_por_hold: assert property (por_cnt_q < 12'h400 |-> chip_reset)
        else $error("chip reset released inside start-up delay");
    a_wake_delay: assert property ($fell(core_stall) && halt_seen_q |-> stall_cnt_q >= 12'h400)
        else $error("halt wake shorter than start-up delay");
    a_warm_pulse: assert property (warm_reset |-> !chip_reset && pc_sp_load ##1 !warm_reset)
        else $error("warm reset not a lone one-cycle load");
    a_warm_flags: assert property (warm_reset |-> timeout_flag && powerdown_flag)
        else $error("warm reset flags wrong");
    a_pc_zero: assert property (pc_sp_load |-> pc_init == 16'h0000 && sp_init == rcs_pkg::SP_TOP)
        else $error("load values wrong");
    a_chip_load: assert property (chip_reset |-> pc_sp_load)
        else $error("chip reset without counter load");
    a_pin_hold: assert property ($fell(chip_reset) |-> $past(external_reset_pin_n))
        else $error("chip reset ended with pin low");
    a_halt_flags: assert property (
        clk_en && halt_exec && !core_stall && external_reset_pin_n
        |=> powerdown_flag && !timeout_flag)
        else $error("halt entry flags wrong");
    a_pin_run: assert property (
        clk_en && !core_stall && !external_reset_pin_n
        |=> chip_reset && $stable(timeout_flag) && $stable(powerdown_flag))
        else $error("pin reset in run wrong");
endmodule : rcs_checker

bind rcs_reset_cause_sequencer rcs_checker i_rcs_checker (
    .core_clk, .rst_n, .clk_en, .external_reset_pin_n, .halt_exec, .chip_reset, .warm_reset,
    .core_stall, .pc_init, .sp_init, .pc_sp_load, .timeout_flag, .powerdown_flag
);

// File: tb/rcs_reset_wdt_model.sv
`timescale 1ns/1ps
module rcs_reset_wdt_model (
    input  wire logic       core_clk,
    input  wire logic [3:0] tick_div,
    output logic            wdt_tick,
    output logic            external_reset_pin_n
);
    logic [3:0] div_q;

    initial
    begin
        wdt_tick = 1'b0;
        external_reset_pin_n = 1'b1;
        div_q = 4'h0;
    end

    // Zero stops ticking; larger values give a slow watchdog clock
    always @(posedge core_clk)
    begin
        wdt_tick <= (tick_div != 4'h0) && (div_q == 4'h0);
        div_q <= (div_q + 4'h1 >= tick_div) ? 4'h0 : div_q + 4'h1;
    end

    // Pin has a pull-up, so release returns it high
    task automatic press(input int len);
        @(posedge core_clk);
        external_reset_pin_n <= 1'b0;
        repeat (len) @(posedge core_clk);
        external_reset_pin_n <= 1'b1;
    endtask : press
endmodule : rcs_reset_wdt_model

// File: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) chk(16'(g), 16'(e))
module testbench;
    typedef struct packed {logic wr; logic [3:0] a; logic [7:0] d; logic [7:0] e;} rcs_row_t;
    logic                       core_clk;
    logic                       rst_n;
    logic                       clk_en;
    logic [2:0]                 ev;
    logic [3:0]                 tick_div;
    logic [rcs_pkg::ADDR_W-1:0] reg_addr;
    logic [rcs_pkg::DATA_W-1:0] reg_wdata;
    logic [rcs_pkg::DATA_W-1:0] reg_rdata;
    logic                       reg_wr, reg_rd, irq, chip_reset, warm_reset, core_stall;
    logic                       pc_sp_load, timeout_flag, powerdown_flag, wdt_tick, pin_n;
    logic [rcs_pkg::PC_W-1:0]   pc_init;
    logic [rcs_pkg::SP_W-1:0]   sp_init;
    logic [7:0]                 rd;
    int                         n_mismatch, check_count, n;
    rcs_row_t rows [5] = '{'{1'b1, 4'h3, 8'h81, 8'h81}, '{1'b1, 4'h2, 8'hff, 8'h07},
        '{1'b1, 4'h2, 8'h00, 8'h00}, '{1'b1, 4'h7, 8'h5a, 8'h00}, '{1'b0, 4'h0, 8'h00, 8'h00}};

    rcs_reset_cause_sequencer i_rcs_reset_cause_sequencer (
        .core_clk, .rst_n, .clk_en, .external_reset_pin_n(pin_n), .halt_exec(ev[0]),
        .wdt_clear_exec(ev[2]), .wdt_tick, .wake_req(ev[1]), .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .irq, .chip_reset, .warm_reset, .core_stall, .pc_init, .sp_init,
        .pc_sp_load, .timeout_flag, .powerdown_flag);
    rcs_reset_wdt_model i_partner (.core_clk, .tick_div, .wdt_tick,
        .external_reset_pin_n(pin_n));

    initial core_clk = 1'b0;
    always #5 core_clk = ~core_clk;

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // Bit 0 halt, bit 1 wake, bit 2 watchdog clear
    task automatic strobe(input int s);
        @(posedge core_clk);
        ev <= 3'(1 << s);
        @(posedge core_clk);
        ev <= 3'h0;
        #1;
    endtask : strobe

    // Bounded wait: 0 chip reset, 1 stall, 2 warm reset
    task automatic wait_sig(input int s, input logic lvl, input int lim, output int cnt);
        logic v;
        cnt = 0;
        v = ~lvl;
        while (v !== lvl)
        begin
            @(posedge core_clk);
            #1 v = (s == 0) ? chip_reset : (s == 1) ? core_stall : warm_reset;
            cnt++;
            if (cnt > lim)
            begin
                n_mismatch++;
                end_of_test();
            end
        end
    endtask : wait_sig

    initial
    begin
        n_mismatch = 0;
        check_count = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        ev = 3'h0;
        tick_div = 4'h0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK({chip_reset, core_stall, pc_sp_load, timeout_flag, powerdown_flag}, 5'b11100);
        rst_n <= 1'b1;
        wait_sig(0, 1'b0, 1100, n);
        `CHK(n >= 1024, 1'b1);
        wait_sig(1, 1'b0, 10, n);
        reg_read(rcs_pkg::ADDR_IRQ_STAT, rd);
        foreach (rows[i])
        begin
            if (rows[i].wr)
                reg_write(rows[i].a, rows[i].d);
            reg_read(rows[i].a, rd);
            `CHK(rd, rows[i].e);
        end
        // Wake from halt, first with the event masked, then unmasked
        for (int m = 0; m < 2; m++)
        begin
            reg_write(rcs_pkg::ADDR_IRQ_MASK, 8'(m * 4));
            strobe(0);
            `CHK({timeout_flag, powerdown_flag, core_stall}, 3'b011);
            repeat (4) @(posedge core_clk);
            strobe(1);
            wait_sig(1, 1'b0, 1100, n);
            `CHK(n >= 1024 && n <= 1032, 1'b1);
            repeat (2) @(posedge core_clk);
            `CHK(irq, m[0]);
            reg_read(rcs_pkg::ADDR_IRQ_STAT, rd);
            `CHK(rd[2], 1'b1);
            repeat (2) @(posedge core_clk);
            `CHK(irq, 1'b0);
        end
        reg_write(rcs_pkg::ADDR_CTRL, 8'h80);
        i_partner.press(10);
        wait_sig(0, 1'b0, 1100, n);
        `CHK(n <= 3, 1'b1);
        `CHK({timeout_flag, powerdown_flag}, 2'b01);
        reg_read(rcs_pkg::ADDR_CTRL, rd);
        `CHK(rd, 8'h01);
        tick_div <= 4'h1;
        wait_sig(0, 1'b1, 300, n);
        `CHK({timeout_flag, powerdown_flag}, 2'b11);
        wait_sig(0, 1'b0, 5, n);
        wait_sig(0, 1'b1, 300, n);
        `CHK(n >= 250 && n <= 260, 1'b1);
        tick_div <= 4'h0;
        strobe(2);
        `CHK({timeout_flag, powerdown_flag}, 2'b10);
        reg_write(rcs_pkg::ADDR_CTRL, 8'h81);
        reg_write(rcs_pkg::ADDR_IRQ_MASK, 8'h02);
        strobe(0);
        tick_div <= 4'h2;
        wait_sig(2, 1'b1, 700, n);
        `CHK({chip_reset, timeout_flag, powerdown_flag}, 3'b011);
        tick_div <= 4'h0;
        wait_sig(1, 1'b0, 1100, n);
        `CHK(n >= 1024, 1'b1);
        `CHK(irq, 1'b1);
        reg_read(rcs_pkg::ADDR_CTRL, rd);
        `CHK(rd, 8'h81);
        reg_read(rcs_pkg::ADDR_IRQ_MASK, rd);
        `CHK(rd, 8'h02);
        strobe(0);
        i_partner.press(20);
        `CHK({chip_reset, timeout_flag, powerdown_flag}, 3'b101);
        wait_sig(0, 1'b0, 1100, n);
        `CHK(n >= 1024, 1'b1);
        // Frozen clock enable: a halt strobe must not be taken
        clk_en <= 1'b0;
        strobe(0);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(core_stall, 1'b0);
        clk_en <= 1'b1;
        end_of_test();
    end
endmodule : testbench
